// File: logic/bbnl_regs.sv
/*
 * bbnl_regs: latency count, header layout code and bus number registers of a
 * pci-to-pci bridge, with the decode of type 1 configuration bus numbers.
 * assumes: the primary target logic hands over decoded config reads and writes;
 * the master state machines report frame, grant and data phase events.
 */
`timescale 1ns/10ps

module bbnl_regs
(
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	// configuration access
	input  wire bbnl_pkg::bbnl_cfg_req_s cfg_req,
	output logic [31:0]                 cfg_rdata,
	output logic                        cfg_ack,
	// upstream mastering
	input  wire logic                   up_frame_start,
	input  wire logic                   up_mastering,
	input  wire logic                   up_gnt_n,
	input  wire logic                   up_data_phase_done,
	input  wire logic                   up_mwi,
	output logic                        up_stop_master,
	// type 1 decode
	input  wire bbnl_pkg::bbnl_type1_s  pri_type1,
	input  wire logic                   pri_special,
	input  wire bbnl_pkg::bbnl_type1_s  sec_type1,
	output logic                        pri_claim,
	output bbnl_pkg::bbnl_fwd_e         pri_fwd,
	output logic                        sec_to_special,
	output logic                        sec_pass_up,
	// register views
	output logic [7:0]                  lat_count,
	output logic [7:0]                  up_bus,
	output logic [7:0]                  dn_bus,
	output logic [7:0]                  hi_bus
);

	// ******************************
	// register file
	// ******************************
	logic [7:0]  lat_q, lat_d;
	logic [7:0]  up_q, up_d;
	logic [7:0]  dn_q, dn_d;
	logic [7:0]  hi_q, hi_d;
	logic [31:0] rdata_q, rdata_d;
	logic        ack_q, ack_d;
	logic        wr_lat, wr_bus;

	assign wr_lat = cfg_req.wr && (cfg_req.ofs == bbnl_pkg::OFS_LAT_HDR);
	assign wr_bus = cfg_req.wr && (cfg_req.ofs == bbnl_pkg::OFS_BUS_NUMBERS);

	always_comb
	begin
		lat_d   = lat_q;
		up_d    = up_q;
		dn_d    = dn_q;
		hi_d    = hi_q;
		rdata_d = rdata_q;
		ack_d   = cfg_req.rd || cfg_req.wr;
		// layout code lane carries no storage, so writes there fall away
		if (wr_lat && !cfg_req.upstream_cmd_byte_lane_n[bbnl_pkg::LANE_LAT])
			lat_d = cfg_req.wdata[bbnl_pkg::LAT_LSB +: 8];
		if (wr_bus && !cfg_req.upstream_cmd_byte_lane_n[bbnl_pkg::LANE_UP])
			up_d = cfg_req.wdata[bbnl_pkg::UP_LSB +: 8];
		if (wr_bus && !cfg_req.upstream_cmd_byte_lane_n[bbnl_pkg::LANE_DN])
			dn_d = cfg_req.wdata[bbnl_pkg::DN_LSB +: 8];
		if (wr_bus && !cfg_req.upstream_cmd_byte_lane_n[bbnl_pkg::LANE_HI])
			hi_d = cfg_req.wdata[bbnl_pkg::HI_LSB +: 8];
		if (cfg_req.rd)
		begin
			rdata_d = 32'h0000_0000;
			if (cfg_req.ofs == bbnl_pkg::OFS_LAT_HDR)
			begin
				rdata_d[bbnl_pkg::LAT_LSB +: 8] = lat_q;
				rdata_d[bbnl_pkg::HDR_LSB +: 8] = bbnl_pkg::HDR_LAYOUT;
			end
			else if (cfg_req.ofs == bbnl_pkg::OFS_BUS_NUMBERS)
			begin
				rdata_d[bbnl_pkg::UP_LSB +: 8] = up_q;
				rdata_d[bbnl_pkg::DN_LSB +: 8] = dn_q;
				rdata_d[bbnl_pkg::HI_LSB +: 8] = hi_q;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			lat_q   <= bbnl_pkg::LAT_RESET;
			up_q    <= bbnl_pkg::BUS_RESET;
			dn_q    <= bbnl_pkg::BUS_RESET;
			hi_q    <= bbnl_pkg::BUS_RESET;
			rdata_q <= 32'h0000_0000;
			ack_q   <= 1'b0;
		end
		else
		begin
			lat_q   <= lat_d;
			up_q    <= up_d;
			dn_q    <= dn_d;
			hi_q    <= hi_d;
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
		end
	end

	assign cfg_rdata = rdata_q;
	assign cfg_ack   = ack_q;
	assign lat_count = lat_q;
	assign up_bus    = up_q;
	assign dn_bus    = dn_q;
	assign hi_bus    = hi_q;

	// ******************************
	// latency timer and bus release
	// ******************************
	logic expired;

	bbnl_lat_timer u_timer
	(
		.sys_clk     (sys_clk),
		.sys_rst     (sys_rst),
		.lat_count   (lat_q),
		.frame_start (up_frame_start),
		.mastering   (up_mastering),
		.expired     (expired)
	);

	// mwi is exempt only for the zero setting; a running timer still ends it
	assign up_stop_master = up_mastering && up_gnt_n && up_data_phase_done &&
		(((lat_q == bbnl_pkg::LAT_ZERO) && !up_mwi) ||
		 ((lat_q != bbnl_pkg::LAT_ZERO) && expired));

	// ******************************
	// type 1 bus number decode
	// ******************************
	logic in_range;

	assign in_range = (pri_type1.bus >= dn_q) && (pri_type1.bus <= hi_q);

	always_comb
	begin
		pri_claim = pri_type1.valid && in_range;
		pri_fwd   = bbnl_pkg::BBNL_FWD_NONE;
		if (pri_claim)
		begin
			if (pri_type1.bus != dn_q)
				pri_fwd = bbnl_pkg::BBNL_FWD_TYPE1;
			else if (pri_special)
				pri_fwd = bbnl_pkg::BBNL_FWD_SPECIAL;
			else
				pri_fwd = bbnl_pkg::BBNL_FWD_TYPE0;
		end
	end

	// a secondary cycle aimed back at our own range is not passed up
	assign sec_to_special = sec_type1.valid && (sec_type1.bus == up_q);
	assign sec_pass_up    = sec_type1.valid && (sec_type1.bus != up_q) &&
		!((sec_type1.bus >= dn_q) && (sec_type1.bus <= hi_q));

	// ******************************
	// assertions
	// ******************************
	property p_hdr_read;
		@(posedge sys_clk) disable iff (sys_rst)
		cfg_req.rd && cfg_req.ofs == bbnl_pkg::OFS_LAT_HDR |=> cfg_rdata[23:16] == 8'h01;
	endproperty
	a_hdr_read: assert property (p_hdr_read) else $error("layout code not 0x01");

	property p_lat_write;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_lat && !cfg_req.upstream_cmd_byte_lane_n[1] |=> lat_count == $past(cfg_req.wdata[15:8]);
	endproperty
	a_lat_write: assert property (p_lat_write) else $error("latency write lost");

	property p_lat_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		!wr_lat |=> lat_count == $past(lat_count);
	endproperty
	a_lat_hold: assert property (p_lat_hold) else $error("latency changed without write");

	property p_bus_readback;
		@(posedge sys_clk) disable iff (sys_rst)
		cfg_req.rd && cfg_req.ofs == bbnl_pkg::OFS_BUS_NUMBERS
		|=> cfg_rdata == {8'h00, $past(hi_q), $past(dn_q), $past(up_q)};
	endproperty
	a_bus_readback: assert property (p_bus_readback) else $error("bus dword wrong");

	property p_zero_release;
		@(posedge sys_clk) disable iff (sys_rst)
		up_mastering && up_gnt_n && up_data_phase_done && lat_q == 8'h00 && !up_mwi
		|-> up_stop_master;
	endproperty
	a_zero_release: assert property (p_zero_release) else $error("no release at zero");

	property p_expiry;
		@(posedge sys_clk) disable iff (sys_rst)
		up_frame_start && up_mastering && lat_q == 8'h03
		##1 (up_mastering && !up_frame_start) [*3]
		|=> expired;
	endproperty
	a_expiry: assert property (p_expiry) else $error("timer expiry off");

	property p_claim;
		@(posedge sys_clk) disable iff (sys_rst)
		pri_claim |-> pri_type1.bus >= dn_q && pri_type1.bus <= hi_q;
	endproperty
	a_claim: assert property (p_claim) else $error("claim out of range");

	property p_type0;
		@(posedge sys_clk) disable iff (sys_rst)
		pri_type1.valid && pri_type1.bus == dn_q && dn_q <= hi_q && !pri_special
		|-> pri_fwd == bbnl_pkg::BBNL_FWD_TYPE0;
	endproperty
	a_type0: assert property (p_type0) else $error("type 0 conversion missed");

	property p_type1;
		@(posedge sys_clk) disable iff (sys_rst)
		pri_type1.valid && pri_type1.bus > dn_q && pri_type1.bus <= hi_q
		|-> pri_fwd == bbnl_pkg::BBNL_FWD_TYPE1;
	endproperty
	a_type1: assert property (p_type1) else $error("type 1 pass missed");

	property p_sec_special;
		@(posedge sys_clk) disable iff (sys_rst)
		sec_type1.valid && sec_type1.bus == up_q |-> sec_to_special && !sec_pass_up;
	endproperty
	a_sec_special: assert property (p_sec_special) else $error("upstream special missed");

	c_release: cover property (@(posedge sys_clk) disable iff (sys_rst) up_stop_master);
	c_fwd_t1:  cover property (@(posedge sys_clk) disable iff (sys_rst)
		pri_fwd == bbnl_pkg::BBNL_FWD_TYPE1);
	c_special: cover property (@(posedge sys_clk) disable iff (sys_rst) sec_to_special);

endmodule : bbnl_regs

// File: logic/bbnl_pkg.sv
/*
 * bbnl_pkg: constants and carriers for the bridge bus number and latency register block.
 * assumes: configuration accesses arrive already decoded to a dword offset with active-low
 * byte lane enables, all synchronous to sys_clk.
 */
package bbnl_pkg;

	// ******************************
	// register map
	// ******************************
	localparam logic [7:0] OFS_LAT_HDR     = 8'h0c;
	localparam logic [7:0] OFS_BUS_NUMBERS = 8'h18;

	localparam int LAT_LSB  = 8;
	localparam int HDR_LSB  = 16;
	localparam int UP_LSB   = 0;
	localparam int DN_LSB   = 8;
	localparam int HI_LSB   = 16;

	localparam int LANE_LAT = 1;
	localparam int LANE_HDR = 2;
	localparam int LANE_UP  = 0;
	localparam int LANE_DN  = 1;
	localparam int LANE_HI  = 2;

	// ******************************
	// reset and fixed values
	// ******************************
	localparam logic [7:0] LAT_RESET   = 8'h00;
	localparam logic [7:0] BUS_RESET   = 8'h00;
	localparam logic [7:0] HDR_LAYOUT  = 8'h01;
	localparam logic [7:0] LAT_ZERO    = 8'h00;

	// ******************************
	// carriers
	// ******************************
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] ofs;
		logic [3:0] upstream_cmd_byte_lane_n;
		logic [31:0] wdata;
	} bbnl_cfg_req_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] bus;
	} bbnl_type1_s;

	typedef enum logic [1:0] {
		BBNL_FWD_NONE    = 2'b00,
		BBNL_FWD_TYPE1   = 2'b01,
		BBNL_FWD_TYPE0   = 2'b10,
		BBNL_FWD_SPECIAL = 2'b11
	} bbnl_fwd_e;

endpackage : bbnl_pkg

// File: logic/bbnl_lat_timer.sv
/*
 * bbnl_lat_timer: master latency timer for the upstream bus.
 * assumes: frame_start pulses in the cycle the frame is first driven by this bridge.
 */
`timescale 1ns/10ps
module bbnl_lat_timer
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// control
	input  wire logic [7:0] lat_count,
	input  wire logic       frame_start,
	input  wire logic       mastering,
	// status
	output logic            expired
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       exp_q;
	logic       exp_d;

	// counts one per clock from frame start; zero setting expires at once
	always_comb
	begin
		cnt_d = cnt_q;
		exp_d = exp_q;
		if (!mastering)
		begin
			cnt_d = bbnl_pkg::LAT_ZERO;
			exp_d = 1'b0;
		end
		else if (frame_start)
		begin
			cnt_d = lat_count;
			exp_d = (lat_count == bbnl_pkg::LAT_ZERO);
		end
		else if (cnt_q != bbnl_pkg::LAT_ZERO)
		begin
			cnt_d = cnt_q - 8'h01;
			exp_d = (cnt_q == 8'h01);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			cnt_q <= bbnl_pkg::LAT_ZERO;
			exp_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign expired = exp_q;

endmodule : bbnl_lat_timer

// File: bench/bbnl_cfg_master.sv
/* bbnl_cfg_master: configuration master on the upstream bus, one dword access per call.
   assumes: the block takes a pulse request and answers with cfg_ack one cycle later. */
`timescale 1ns/10ps
module bbnl_cfg_master
(
	// clock
	input  wire logic                    sys_clk,
	// request and answer
	output bbnl_pkg::bbnl_cfg_req_s      cfg_req,
	input  wire logic [31:0]             cfg_rdata,
	input  wire logic                    cfg_ack
);
	// ******************************
	// access task
	// ******************************
	logic [31:0] rdata_q;
	logic        ack_q;
	initial cfg_req = '0;
	task automatic xfer(input logic w, input logic [7:0] ofs, input logic [3:0] lanes_n,
		input logic [31:0] wdata);
	begin
		@(posedge sys_clk);
		#1;
		cfg_req.rd = !w;
		cfg_req.wr = w;
		cfg_req.ofs = ofs;
		cfg_req.upstream_cmd_byte_lane_n = lanes_n;
		cfg_req.wdata = wdata;
		@(posedge sys_clk);
		#1;
		rdata_q = cfg_rdata;
		ack_q = cfg_ack;
		// released lines show garbage, not the last value
		cfg_req = '{rd: 1'b0, wr: 1'b0, ofs: ~ofs, upstream_cmd_byte_lane_n: ~lanes_n,
			wdata: ~wdata};
	end
	endtask : xfer
endmodule : bbnl_cfg_master

// File: bench/test_bridge_bus_number_latency_regs.sv
/* test_bridge_bus_number_latency_regs: register, decode and latency timer tests.
   assumes: bbnl_pkg compiled first; one 20 MHz clock, synchronous reset. */
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: compare mismatch", $time); end end
module test_bridge_bus_number_latency_regs;
	// ******************************
	// design and partner
	// ******************************
	logic                    sys_clk = 1'b0;
	logic                    sys_rst = 1'b1;
	bbnl_pkg::bbnl_cfg_req_s cfg_req;
	logic [31:0]             cfg_rdata;
	logic                    cfg_ack, fs, mst, gnt_n, dpd, mwi, stop;
	bbnl_pkg::bbnl_type1_s   pt1, st1;
	logic                    psp, claim, to_sp, pass_up;
	bbnl_pkg::bbnl_fwd_e     fwd;
	logic [7:0]              lat, upb, dnb, hib;
	int                      n_fail = 0, cmp_count = 0, cyc = 0;
	always #25 sys_clk = ~sys_clk;
	bbnl_cfg_master bbnl_cfg_master_inst (.sys_clk(sys_clk), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
	bbnl_regs bbnl_regs_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .up_frame_start(fs), .up_mastering(mst),
		.up_gnt_n(gnt_n), .up_data_phase_done(dpd), .up_mwi(mwi), .up_stop_master(stop),
		.pri_type1(pt1), .pri_special(psp), .sec_type1(st1), .pri_claim(claim),
		.pri_fwd(fwd), .sec_to_special(to_sp), .sec_pass_up(pass_up), .lat_count(lat),
		.up_bus(upb), .dn_bus(dnb), .hi_bus(hib));
	// ******************************
	// tasks
	// ******************************
	task automatic stop_test;
	begin
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask : stop_test
	task automatic wr(input logic [7:0] ofs, input logic [3:0] ln, input logic [31:0] d);
	begin
		bbnl_cfg_master_inst.xfer(1'b1, ofs, ln, d);
		`CHK(bbnl_cfg_master_inst.ack_q, 1'b1)
	end
	endtask : wr
	task automatic rd(input logic [7:0] ofs, input logic [31:0] e);
	begin
		bbnl_cfg_master_inst.xfer(1'b0, ofs, 4'h0, 32'h0);
		`CHK(bbnl_cfg_master_inst.ack_q, 1'b1)
		`CHK(bbnl_cfg_master_inst.rdata_q, e)
	end
	endtask : rd
	task automatic dec(input logic [7:0] pb, input logic sp, input logic [7:0] sb,
		input logic ec, input bbnl_pkg::bbnl_fwd_e ef, input logic es, input logic ep);
	begin
		@(posedge sys_clk);
		#1;
		pt1 = {1'b1, pb};
		psp = sp;
		st1 = {1'b1, sb};
		#1;
		`CHK({claim, fwd, to_sp, pass_up}, {ec, ef, es, ep})
	end
	endtask : dec
	task automatic bus_ctl(input logic m, input logic g, input logic w, input logic e);
	begin
		@(posedge sys_clk);
		#1;
		{mst, gnt_n, dpd, mwi, fs} = {m, g, 1'b1, w, 1'b0};
		#1;
		`CHK(stop, e)
	end
	endtask : bus_ctl
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			stop_test;
		end
	end
	// ******************************
	// sequence
	// ******************************
	initial
	begin
		{fs, mst, gnt_n, dpd, mwi, psp} = '0;
		pt1 = '0;
		st1 = '0;
		repeat (12) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		rd(8'h0c, {8'h00, bbnl_pkg::HDR_LAYOUT, 16'h0000});
		rd(8'h18, 32'h0);
		wr(8'h0c, 4'h0, 32'hffffffff);
		rd(8'h0c, 32'h0001ff00);
		`CHK(lat, 8'hff)
		wr(8'h18, 4'h8, 32'haa050201);
		rd(8'h18, 32'h00050201);
		wr(8'h18, 4'hd, 32'h00000700);
		rd(8'h18, 32'h00050701);
		`CHK({upb, dnb, hib}, 24'h010705)
		wr(8'h18, 4'hd, 32'h00000200);
		rd(8'h20, 32'h0);
		// up 1, down 2, highest 5
		dec(8'h02, 1'b0, 8'h01, 1'b1, bbnl_pkg::BBNL_FWD_TYPE0, 1'b1, 1'b0);
		dec(8'h02, 1'b1, 8'h09, 1'b1, bbnl_pkg::BBNL_FWD_SPECIAL, 1'b0, 1'b1);
		dec(8'h05, 1'b0, 8'h03, 1'b1, bbnl_pkg::BBNL_FWD_TYPE1, 1'b0, 1'b0);
		dec(8'h01, 1'b0, 8'h06, 1'b0, bbnl_pkg::BBNL_FWD_NONE, 1'b0, 1'b1);
		dec(8'h06, 1'b0, 8'h00, 1'b0, bbnl_pkg::BBNL_FWD_NONE, 1'b0, 1'b1);
		// latency count of 3, frame started with grant already removed
		wr(8'h0c, 4'hd, 32'h00000300);
		@(posedge sys_clk);
		#1;
		{mst, gnt_n, dpd, fs} = 4'hf;
		bus_ctl(1'b1, 1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK(stop, 1'b1)
		bus_ctl(1'b1, 1'b0, 1'b0, 1'b0);
		bus_ctl(1'b0, 1'b1, 1'b0, 1'b0);
		wr(8'h0c, 4'hd, 32'h00000000);
		bus_ctl(1'b1, 1'b1, 1'b0, 1'b1);
		bus_ctl(1'b1, 1'b1, 1'b1, 1'b0);
		bus_ctl(1'b1, 1'b0, 1'b0, 1'b0);
		stop_test;
	end
endmodule : test_bridge_bus_number_latency_regs
